// ==== hw/at_pkg.sv ====
package at_pkg;

	// counter geometry
	localparam int              CNT_W   = 12;
	localparam logic [11:0]     CNT_MAX = 12'hFFF;
	localparam logic [11:0]     CNT_RST = 12'h000;

	// register indices; byte address is four times the index
	localparam int              IDX_W        = 6;
	localparam logic [5:0]      IDX_CTRL     = 6'h0D;
	localparam logic [5:0]      IDX_CNT_HI   = 6'h0E;
	localparam logic [5:0]      IDX_CNT_LO   = 6'h0F;
	localparam logic [5:0]      IDX_RLD_HI   = 6'h10;
	localparam logic [5:0]      IDX_RLD_LO   = 6'h11;
	localparam logic [5:0]      IDX_OUT_CTRL = 6'h12;
	localparam logic [5:0]      IDX_CMP_STAT = 6'h13;
	localparam logic [5:0]      IDX_DUTY_HI  = 6'h17;
	localparam logic [5:0]      IDX_DUTY_LO  = 6'h18;

	// timer_control_status fields
	localparam int              CS_SEL_HI = 4;
	localparam int              CS_SEL_LO = 3;
	localparam int              CS_OVF    = 2;
	localparam int              CS_OVERFLOW_IRQ_ENABLE  = 1;
	localparam int              CS_COMPARE_IRQ_ENABLE  = 0;
	// compare_status_reg fields
	localparam int              CMP_INV   = 1;
	localparam int              CMP_FLAG  = 0;
	// output_control_reg fields
	localparam int              OC_OE     = 0;

	localparam logic [7:0]      REG_RST   = 8'h00;

	// counter_clock_select codes
	localparam logic [1:0]      SEL_OFF   = 2'h0;
	localparam logic [1:0]      SEL_SLOW  = 2'h1;
	localparam logic [1:0]      SEL_CPU   = 2'h2;

	// slow-mode divider
	localparam int              SLOW_DIV  = 32;
	localparam logic [4:0]      DIV_LAST  = 5'(SLOW_DIV - 1);
	localparam logic [4:0]      DIV_RST   = 5'h00;

	// system power state as seen by the timer
	typedef struct packed {
		logic slowMode;
		logic haltMode;
		logic activeHalt;
		logic cpuIrqMask;
	} power_s;

endpackage

// ==== hw/at_tick_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module at_tick_gen (
	// system
	input  wire logic         clk,
	input  wire logic         rst_n,
	// selection
	input  wire logic [1:0]   clockSel,
	input  wire logic         slowTick,
	input  wire logic         ovfIrqEnable,
	input  wire at_pkg::power_s power,
	// counter clock enable
	output logic              tick
);

	logic       rawTick;
	logic       run;
	logic [4:0] div_q;
	logic [4:0] div_d;

	// halt stops the timer; active-halt only lets the slow timebase through, and only with the overflow interrupt enabled
	assign run = !power.haltMode &&
		(!power.activeHalt || (clockSel == at_pkg::SEL_SLOW && ovfIrqEnable));
	// reserved code 11 behaves as off
	assign rawTick = (clockSel == at_pkg::SEL_SLOW) ? slowTick :
		(clockSel == at_pkg::SEL_CPU);
	assign tick = run && rawTick &&
		(!power.slowMode || div_q == at_pkg::DIV_LAST);

	always_comb begin
		div_d = div_q;
		if (!power.slowMode) begin
			div_d = at_pkg::DIV_RST;
		end else if (run && rawTick) begin
			div_d = div_q + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q <= at_pkg::DIV_RST;
		end else begin
			div_q <= div_d;
		end
	end

	property p_halt_stops;
		@(posedge clk) disable iff (!rst_n)
		power.haltMode |-> !tick;
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("tick during halt");

	property p_slow_div;
		@(posedge clk) disable iff (!rst_n)
		(tick && power.slowMode) |-> (div_q == 5'h1F);
	endproperty
	a_slow_div: assert property (p_slow_div) else $error("slow tick not every 32");

endmodule
`default_nettype wire

// ==== hw/at_pulse_drive.sv ====
`timescale 1ns/1ns
`default_nettype none
module at_pulse_drive (
	// system
	input  wire logic clk,
	input  wire logic rst_n,
	// events from the counter
	input  wire logic ovfEvt,
	input  wire logic hit,
	// control
	input  wire logic pwmMode,
	input  wire logic invert,
	// pin
	output logic      pulseOut,
	output logic      pulseOe
);

	logic raw_q;
	logic raw_d;
	logic pulseOut_d;

	always_comb begin
		raw_d = raw_q;
		if (ovfEvt) begin
			// duty equal to reload means the match lands on the overflow: 0%
			raw_d = !hit;
		end else if (hit) begin
			raw_d = 1'b0;
		end
		// compare mode drives no pulse
		pulseOut_d = pwmMode ? (raw_d ^ invert) : 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			raw_q    <= 1'b0;
			pulseOut <= 1'b0;
			pulseOe  <= 1'b0;
		end else begin
			raw_q    <= raw_d;
			pulseOut <= pulseOut_d;
			pulseOe  <= pwmMode;
		end
	end

	property p_polarity;
		@(posedge clk) disable iff (!rst_n)
		pwmMode |=> (pulseOut == (raw_q ^ $past(invert)));
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity wrong");

	property p_match_low;
		@(posedge clk) disable iff (!rst_n)
		(hit && !ovfEvt) |=> !raw_q;
	endproperty
	a_match_low: assert property (p_match_low) else $error("match did not drive low");

endmodule
`default_nettype wire

// ==== hw/autoreload_timer.sv ====
// Notes on behaviour
// - output-enable set makes the block drive the pulse pin; clear frees it.
// - pulse period is 4096 minus reload counter ticks.
// - counter starts from zero after reset.
// - overflow reloads counter, moves duty to shadow, sets pulse high.
// - counter equal to active duty drives pulse low until overflow.
// - polarity bit inverts the pulse output.
// - one step resolution; duty equal reload gives 0% or 100%.
// - high-byte write suspends compare until low byte written.
// - in compare mode a written duty compares at once.
// - counter reaching compare value sets flag, requests interrupt if enabled.
// - compare events need a nonzero duty value.
// - shadow copied each overflow; pulse mode uses shadow, compare mode duty.
// - slow mode divides the counter clock by 32; wait has no effect.
// - halt stops; active-halt runs only on slow timebase with overflow enabled.
// - separate overflow and compare requests, gated by enable and CPU mask.
// - clock select bits 4:3 reset to off; 01 slow, 10 CPU, 11 reserved.
// - overflow flag set on FFF to reload; control read clears it.
// - cleared overflow flag reads high for one more counter tick.
// - compare flag clears on compare status read, not on write.
// - compare interrupt enable masks the request, not the flag, and resets clear.
`timescale 1ns/1ns
`default_nettype none
module autoreload_timer (
	// system
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]    address,
	input  wire logic          read,
	input  wire logic          write,
	input  wire logic [31:0]   writedata,
	input  wire logic [3:0]    byteenable,
	output logic [31:0]        readdata,
	output logic               waitrequest,
	// clocking and power
	input  wire logic          slowTick,
	input  wire at_pkg::power_s power,
	// pulse pin
	output logic               pulseOut,
	output logic               pulseOe,
	// interrupt requests and wake-ups
	output logic               ovfIrq,
	output logic               cmpIrq,
	output logic               waitWake,
	output logic               haltWake
);

	// writes the low or high part of a 12-bit value
	function automatic logic [11:0] setPart(input logic [11:0] old, input logic [7:0] b,
		input logic hi);
		return hi ? {b[3:0], old[7:0]} : {old[11:8], b};
	endfunction

	logic [11:0] cnt_q,     cnt_d;
	logic [11:0] reload_q,  reload_d;
	logic [11:0] duty_q,    duty_d;
	logic [11:0] shadow_q,  shadow_d;
	logic [1:0]  clkSel_q,  clkSel_d;
	logic        ovf_q,     ovf_d;
	logic        ovfClr_q,  ovfClr_d;
	logic        overflow_irq_enable_q,   overflow_irq_enable_d;
	logic        compare_irq_enable_q,   compare_irq_enable_d;
	logic        cmpf_q,    cmpf_d;
	logic        invert_q,  invert_d;
	logic        oe_q,      oe_d;
	logic        lock_q,    lock_d;
	logic [31:0] readdata_d;
	logic        wait_d;
	logic        ovfIrq_d, cmpIrq_d, waitWake_d, haltWake_d;

	logic        tick;
	logic        req;
	logic        acc;
	logic        wrAcc;
	logic        rdAcc;
	logic [5:0]  idx;
	logic [7:0]  wb;
	logic        ovfEvt;
	logic [11:0] nxtCnt;
	logic [11:0] cmpVal;
	logic        hit;
	logic [7:0]  rdByte;

	at_tick_gen u_tick (
		.clk          (clk),
		.rst_n        (rst_n),
		.clockSel     (clkSel_q),
		.slowTick     (slowTick),
		.ovfIrqEnable (overflow_irq_enable_q),
		.power        (power),
		.tick         (tick)
	);

	at_pulse_drive u_pulse (
		.clk      (clk),
		.rst_n    (rst_n),
		.ovfEvt   (ovfEvt),
		.hit      (hit),
		.pwmMode  (oe_q),
		.invert   (invert_q),
		.pulseOut (pulseOut),
		.pulseOe  (pulseOe)
	);

	// bus: one wait cycle, then the access completes while waitrequest is low
	assign req   = read || write;
	assign acc   = req && !waitrequest;
	assign wrAcc = acc && write && byteenable[0];
	assign rdAcc = acc && read;
	assign idx   = address[7:2];
	assign wb    = writedata[7:0];

	// counter datapath
	assign ovfEvt = tick && (cnt_q == at_pkg::CNT_MAX);
	assign nxtCnt = ovfEvt ? reload_q : cnt_q + 12'h001;
	// pulse mode looks at the shadow as it stands after this tick
	assign cmpVal = oe_q ? (ovfEvt ? duty_q : shadow_q) : duty_q;
	assign hit    = tick && !lock_q && (nxtCnt == cmpVal);

	always_comb begin
		rdByte = 8'h00;
		case (idx)
			at_pkg::IDX_CTRL:     rdByte = {3'h0, clkSel_q, ovf_q, overflow_irq_enable_q, compare_irq_enable_q};
			at_pkg::IDX_CNT_HI:   rdByte = {4'h0, cnt_q[11:8]};
			at_pkg::IDX_CNT_LO:   rdByte = cnt_q[7:0];
			at_pkg::IDX_RLD_HI:   rdByte = {4'h0, reload_q[11:8]};
			at_pkg::IDX_RLD_LO:   rdByte = reload_q[7:0];
			at_pkg::IDX_OUT_CTRL: rdByte = {7'h00, oe_q};
			at_pkg::IDX_CMP_STAT: rdByte = {6'h00, invert_q, cmpf_q};
			at_pkg::IDX_DUTY_HI:  rdByte = {4'h0, duty_q[11:8]};
			at_pkg::IDX_DUTY_LO:  rdByte = duty_q[7:0];
			default:              rdByte = 8'h00;
		endcase
	end

	always_comb begin
		wait_d     = !(req && waitrequest);
		readdata_d = (req && waitrequest) ? {24'h000000, rdByte} : readdata;
		cnt_d      = tick ? nxtCnt : cnt_q;
		shadow_d   = ovfEvt ? duty_q : shadow_q;
		reload_d   = reload_q;
		duty_d     = duty_q;
		clkSel_d   = clkSel_q;
		overflow_irq_enable_d    = overflow_irq_enable_q;
		compare_irq_enable_d    = compare_irq_enable_q;
		invert_d   = invert_q;
		oe_d       = oe_q;
		lock_d     = lock_q;
		ovf_d      = ovf_q;
		ovfClr_d   = ovfClr_q;
		cmpf_d     = cmpf_q;
		if (wrAcc) begin
			case (idx)
				at_pkg::IDX_CTRL: begin
					clkSel_d = wb[at_pkg::CS_SEL_HI:at_pkg::CS_SEL_LO];
					overflow_irq_enable_d  = wb[at_pkg::CS_OVERFLOW_IRQ_ENABLE];
					compare_irq_enable_d  = wb[at_pkg::CS_COMPARE_IRQ_ENABLE];
				end
				at_pkg::IDX_RLD_HI:   reload_d = setPart(reload_q, wb, 1'b1);
				at_pkg::IDX_RLD_LO:   reload_d = setPart(reload_q, wb, 1'b0);
				at_pkg::IDX_OUT_CTRL: oe_d = wb[at_pkg::OC_OE];
				at_pkg::IDX_CMP_STAT: invert_d = wb[at_pkg::CMP_INV];
				at_pkg::IDX_DUTY_HI: begin
					duty_d = setPart(duty_q, wb, 1'b1);
					lock_d = 1'b1;
				end
				at_pkg::IDX_DUTY_LO: begin
					duty_d = setPart(duty_q, wb, 1'b0);
					lock_d = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// the overflow flag falls only on the counter tick after the read
		if (rdAcc && idx == at_pkg::IDX_CTRL && ovf_q) begin
			ovfClr_d = 1'b1;
		end
		if (tick && ovfClr_q) begin
			ovf_d    = 1'b0;
			ovfClr_d = 1'b0;
		end
		if (ovfEvt) begin
			ovf_d    = 1'b1;
			ovfClr_d = 1'b0;
		end
		// compare flag: read clears, a match in the same cycle wins
		if (rdAcc && idx == at_pkg::IDX_CMP_STAT) begin
			cmpf_d = 1'b0;
		end
		if (hit && cmpVal != at_pkg::CNT_RST) begin
			cmpf_d = 1'b1;
		end
		ovfIrq_d   = ovf_d && overflow_irq_enable_d && !power.cpuIrqMask;
		cmpIrq_d   = cmpf_d && compare_irq_enable_d && !power.cpuIrqMask;
		waitWake_d = ovfIrq_d || cmpIrq_d;
		haltWake_d = power.activeHalt && ovfIrq_d && clkSel_d == at_pkg::SEL_SLOW;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q       <= at_pkg::CNT_RST;
			reload_q    <= at_pkg::CNT_RST;
			duty_q      <= at_pkg::CNT_RST;
			shadow_q    <= at_pkg::CNT_RST;
			clkSel_q    <= at_pkg::SEL_OFF;
			ovf_q       <= 1'b0;
			ovfClr_q    <= 1'b0;
			overflow_irq_enable_q     <= 1'b0;
			compare_irq_enable_q     <= 1'b0;
			cmpf_q      <= 1'b0;
			invert_q    <= 1'b0;
			oe_q        <= 1'b0;
			lock_q      <= 1'b0;
			readdata    <= 32'h00000000;
			waitrequest <= 1'b1;
			ovfIrq      <= 1'b0;
			cmpIrq      <= 1'b0;
			waitWake    <= 1'b0;
			haltWake    <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			reload_q    <= reload_d;
			duty_q      <= duty_d;
			shadow_q    <= shadow_d;
			clkSel_q    <= clkSel_d;
			ovf_q       <= ovf_d;
			ovfClr_q    <= ovfClr_d;
			overflow_irq_enable_q     <= overflow_irq_enable_d;
			compare_irq_enable_q     <= compare_irq_enable_d;
			cmpf_q      <= cmpf_d;
			invert_q    <= invert_d;
			oe_q        <= oe_d;
			lock_q      <= lock_d;
			readdata    <= readdata_d;
			waitrequest <= wait_d;
			ovfIrq      <= ovfIrq_d;
			cmpIrq      <= cmpIrq_d;
			waitWake    <= waitWake_d;
			haltWake    <= haltWake_d;
		end
	end

	property p_reset_zero;
		@(posedge clk) disable iff (!rst_n)
		!$past(rst_n) |-> (cnt_q == 12'h000);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("counter not zero after reset");

	property p_overflow_load;
		@(posedge clk) disable iff (!rst_n)
		(tick && cnt_q == 12'hFFF) |=>
			(cnt_q == $past(reload_q) && shadow_q == $past(duty_q) && ovf_q);
	endproperty
	a_overflow_load: assert property (p_overflow_load) else $error("overflow load wrong");

	property p_step;
		@(posedge clk) disable iff (!rst_n)
		(tick && cnt_q != 12'hFFF) |=> (cnt_q == $past(cnt_q) + 12'h001);
	endproperty
	a_step: assert property (p_step) else $error("counter did not step");

	property p_hold_off;
		@(posedge clk) disable iff (!rst_n)
		(clkSel_q == 2'h0) |=> $stable(cnt_q);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("counter moved while off");

	property p_ovf_linger;
		@(posedge clk) disable iff (!rst_n)
		(ovf_q && !tick) |=> ovf_q;
	endproperty
	a_ovf_linger: assert property (p_ovf_linger) else $error("overflow flag fell early");

	property p_cmpf_write;
		@(posedge clk) disable iff (!rst_n)
		(cmpf_q && !(rdAcc && idx == 6'h13)) |=> cmpf_q;
	endproperty
	a_cmpf_write: assert property (p_cmpf_write) else $error("compare flag lost");

	property p_cmp_nonzero;
		@(posedge clk) disable iff (!rst_n)
		$rose(cmpf_q) |-> ($past(cmpVal) != 12'h000 && !$past(lock_q));
	endproperty
	a_cmp_nonzero: assert property (p_cmp_nonzero) else $error("bad compare event");

	property p_cmp_irq;
		@(posedge clk) disable iff (!rst_n)
		// the request is registered, so it follows the mask as it stood one cycle earlier
		(cmpf_q && compare_irq_enable_q && !$past(power.cpuIrqMask)) |-> cmpIrq;
	endproperty
	a_cmp_irq: assert property (p_cmp_irq) else $error("compare request missing");

endmodule
`default_nettype wire

// ==== sim/autoreload_timer_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module autoreload_timer_tb;
	typedef struct packed {
		logic       wr;
		logic [5:0] idx;
		logic [7:0] d;
	} row_s;

	logic           clk;
	logic           rst_n;
	logic [7:0]     address;
	logic           read;
	logic           write;
	logic [31:0]    writedata;
	logic [3:0]     byteenable;
	logic [31:0]    readdata;
	logic           waitrequest;
	logic           slowTick;
	at_pkg::power_s power;
	logic           pulseOut;
	logic           pulseOe;
	logic           ovfIrq;
	logic           cmpIrq;
	logic           waitWake;
	logic           haltWake;
	logic [7:0]     q;
	logic           ok;
	logic [11:0]    tgt;
	int             err_count;
	int             n_compared;
	int             hi;
	int             per;

	// write rows carry data, read rows carry the expected byte
	row_s rows [0:21] = '{
		'{1'h0, at_pkg::IDX_CTRL, 8'h00}, '{1'h0, at_pkg::IDX_CNT_HI, 8'h00},
		'{1'h0, at_pkg::IDX_CNT_LO, 8'h00}, '{1'h0, at_pkg::IDX_RLD_HI, 8'h00},
		'{1'h0, at_pkg::IDX_RLD_LO, 8'h00}, '{1'h0, at_pkg::IDX_OUT_CTRL, 8'h00},
		'{1'h0, at_pkg::IDX_CMP_STAT, 8'h00}, '{1'h0, at_pkg::IDX_DUTY_HI, 8'h00},
		'{1'h0, at_pkg::IDX_DUTY_LO, 8'h00}, '{1'h1, at_pkg::IDX_RLD_HI, 8'hFA},
		'{1'h0, at_pkg::IDX_RLD_HI, 8'h0A}, '{1'h1, at_pkg::IDX_RLD_LO, 8'h5C},
		'{1'h0, at_pkg::IDX_RLD_LO, 8'h5C}, '{1'h1, at_pkg::IDX_DUTY_HI, 8'hF3},
		'{1'h0, at_pkg::IDX_DUTY_HI, 8'h03}, '{1'h1, at_pkg::IDX_CTRL, 8'h06},
		'{1'h0, at_pkg::IDX_CTRL, 8'h02}, '{1'h1, at_pkg::IDX_CMP_STAT, 8'h02},
		'{1'h0, at_pkg::IDX_CMP_STAT, 8'h02}, '{1'h1, 6'h3F, 8'hAA},
		'{1'h0, 6'h3F, 8'h00}, '{1'h1, at_pkg::IDX_CNT_LO, 8'h55}};

	autoreload_timer DUT (
		.clk         (clk),
		.rst_n       (rst_n),
		.address     (address),
		.read        (read),
		.write       (write),
		.writedata   (writedata),
		.byteenable  (byteenable),
		.readdata    (readdata),
		.waitrequest (waitrequest),
		.slowTick    (slowTick),
		.power       (power),
		.pulseOut    (pulseOut),
		.pulseOe     (pulseOe),
		.ovfIrq      (ovfIrq),
		.cmpIrq      (cmpIrq),
		.waitWake    (waitWake),
		.haltWake    (haltWake)
	);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task report_and_stop;
		if (err_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// request held until waitrequest is sampled low, released after that edge
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
			output logic [7:0] rd);
		int n;
		n = 0;
		address   <= {idx, 2'h0};
		writedata <= {24'h000000, d};
		write     <= wr;
		read      <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 20);
		rd = readdata[7:0];
		read  <= 1'h0;
		write <= 1'h0;
		@(posedge clk);
		if (n >= 20) begin
			err_count++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] dummy;
		bus(1'h1, idx, d, dummy);
	endtask

	task automatic ticks(input int k);
		repeat (k) begin
			slowTick <= 1'h1;
			@(posedge clk);
			slowTick <= 1'h0;
			@(posedge clk);
		end
	endtask

	// cycles high and full period of pulseOut, bounded
	task automatic measure(output int h, output int p);
		int n;
		n = 0;
		while (pulseOut !== 1'h0 && n < 9000) begin @(posedge clk); n++; end
		while (pulseOut !== 1'h1 && n < 9000) begin @(posedge clk); n++; end
		h = 0;
		while (pulseOut === 1'h1 && n < 9000) begin @(posedge clk); h++; n++; end
		p = h;
		while (pulseOut !== 1'h1 && n < 9000) begin @(posedge clk); p++; n++; end
		if (n >= 9000) begin
			err_count++;
			report_and_stop();
		end
	endtask

	initial begin
		err_count = 0;
		n_compared = 0;
		rst_n = 1'h0;
		address = 8'h00;
		read = 1'h0;
		write = 1'h0;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		slowTick = 1'h0;
		power = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		`CHK({pulseOut, pulseOe, ovfIrq, cmpIrq}, 4'h0)
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].idx, rows[i].d, q);
			if (!rows[i].wr) `CHK(q, rows[i].d)
		end
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h00)
		byteenable <= 4'h0;
		wr(at_pkg::IDX_RLD_LO, 8'hFF);
		byteenable <= 4'hF;
		bus(1'h0, at_pkg::IDX_RLD_LO, 8'h00, q);
		`CHK(q, 8'h5C)
		// slow timebase counting, halt and active-halt
		wr(at_pkg::IDX_CMP_STAT, 8'h00);
		wr(at_pkg::IDX_RLD_HI, 8'h00);
		wr(at_pkg::IDX_RLD_LO, 8'h00);
		wr(at_pkg::IDX_CTRL, 8'h08);
		ticks(5);
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h05)
		power.haltMode <= 1'h1;
		ticks(3);
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h05)
		power.haltMode <= 1'h0;
		power.activeHalt <= 1'h1;
		ticks(2);
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h05)
		wr(at_pkg::IDX_CTRL, 8'h0A);
		ticks(2);
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h07)
		power.activeHalt <= 1'h0;
		// slow mode lets one tick in 32 through
		power.slowMode <= 1'h1;
		ticks(64);
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h09)
		power.slowMode <= 1'h0;
		// reserved select code counts nothing
		wr(at_pkg::IDX_CTRL, 8'h18);
		ticks(2);
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		`CHK(q, 8'h09)
		// pulse mode: reload FFC gives a 4-cycle period, duty FFF gives 3 high
		wr(at_pkg::IDX_CTRL, 8'h00);
		wr(at_pkg::IDX_RLD_HI, 8'h0F);
		wr(at_pkg::IDX_RLD_LO, 8'hFC);
		wr(at_pkg::IDX_DUTY_HI, 8'h0F);
		wr(at_pkg::IDX_DUTY_LO, 8'hFF);
		wr(at_pkg::IDX_OUT_CTRL, 8'h01);
		wr(at_pkg::IDX_CTRL, 8'h12);
		`CHK(pulseOe, 1'h1)
		measure(hi, per);
		measure(hi, per);
		`CHK(per, 4)
		`CHK(hi, 3)
		`CHK({ovfIrq, waitWake}, 2'h3)
		power.cpuIrqMask <= 1'h1;
		repeat (3) @(posedge clk);
		`CHK(ovfIrq, 1'h0)
		power.cpuIrqMask <= 1'h0;
		wr(at_pkg::IDX_CMP_STAT, 8'h02);
		measure(hi, per);
		measure(hi, per);
		`CHK(hi, 1)
		// duty equal to reload with inversion is a steady high
		wr(at_pkg::IDX_DUTY_HI, 8'h0F);
		wr(at_pkg::IDX_DUTY_LO, 8'hFC);
		repeat (10) @(posedge clk);
		ok = 1'h1;
		repeat (8) begin
			@(posedge clk);
			ok &= (pulseOut === 1'h1);
		end
		`CHK(ok, 1'h1)
		// active-halt wake on a pending overflow; then clear, one overflow, read twice, one tick
		wr(at_pkg::IDX_CTRL, 8'h00);
		wr(at_pkg::IDX_RLD_HI, 8'h00);
		wr(at_pkg::IDX_RLD_LO, 8'h00);
		wr(at_pkg::IDX_CTRL, 8'h0A);
		power.activeHalt <= 1'h1;
		repeat (2) @(posedge clk);
		`CHK({ovfIrq, haltWake}, 2'h3)
		power.activeHalt <= 1'h0;
		wr(at_pkg::IDX_CTRL, 8'h08);
		bus(1'h0, at_pkg::IDX_CTRL, 8'h00, q);
		`CHK(q, 8'h0C)
		ticks(4);
		bus(1'h0, at_pkg::IDX_CTRL, 8'h00, q);
		`CHK(q, 8'h0C)
		bus(1'h0, at_pkg::IDX_CTRL, 8'h00, q);
		`CHK(q, 8'h0C)
		ticks(1);
		bus(1'h0, at_pkg::IDX_CTRL, 8'h00, q);
		`CHK(q, 8'h08)
		// compare mode: no pin drive, flag and request on a match
		wr(at_pkg::IDX_OUT_CTRL, 8'h00);
		wr(at_pkg::IDX_CMP_STAT, 8'h00);
		`CHK({pulseOe, pulseOut}, 2'h0)
		// the flag was also raised in pulse mode; clear it before the compare run
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h01)
		wr(at_pkg::IDX_DUTY_HI, 8'h00);
		wr(at_pkg::IDX_DUTY_LO, 8'h10);
		wr(at_pkg::IDX_CTRL, 8'h11);
		repeat (40) @(posedge clk);
		`CHK(cmpIrq, 1'h1)
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h01)
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h00)
		// a lone high-byte write holds compare off for a whole period
		wr(at_pkg::IDX_DUTY_HI, 8'h00);
		repeat (4200) @(posedge clk);
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h00)
		wr(at_pkg::IDX_DUTY_LO, 8'h10);
		repeat (4200) @(posedge clk);
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h01)
		// stopped counter, duty eight counts ahead: the match comes within 20 cycles, past an overflow if the counter wraps
		wr(at_pkg::IDX_CTRL, 8'h01);
		bus(1'h0, at_pkg::IDX_CNT_HI, 8'h00, q);
		tgt[11:8] = q[3:0];
		bus(1'h0, at_pkg::IDX_CNT_LO, 8'h00, q);
		tgt = {tgt[11:8], q} + 12'h008;
		if (tgt == 12'h000) begin
			tgt = 12'h001;
		end
		wr(at_pkg::IDX_DUTY_HI, {4'h0, tgt[11:8]});
		wr(at_pkg::IDX_DUTY_LO, tgt[7:0]);
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		wr(at_pkg::IDX_CTRL, 8'h11);
		repeat (20) @(posedge clk);
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h01)
		wr(at_pkg::IDX_DUTY_HI, 8'h00);
		wr(at_pkg::IDX_DUTY_LO, 8'h00);
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		repeat (4200) @(posedge clk);
		bus(1'h0, at_pkg::IDX_CMP_STAT, 8'h00, q);
		`CHK(q, 8'h00)
		report_and_stop();
	end
endmodule
`default_nettype wire
